/* File: pkg/exec_defs.svh */
// Notes on behaviour
// RULE1 - or accum with file; d=0 to accum, d=1 to file; zero flag updated
// RULE2 - store accum into file register 0..31; flags unchanged
// RULE3 - move file to accum (d=0) or back to itself (d=1); zero flag set; code sets Z only when the moved value is 00h, else clears it
// RULE4 - load 8-bit literal into accum; no flags changed
// RULE5 - load option register from accum; flags unchanged
// RULE6 - return with literal loads accum with literal; flags unchanged
// RULE7 - return with literal reloads program counter from stack top
// RULE8 - return with literal takes two cycles; prefetched next instruction discarded
// RULE9 - sleep clears watchdog counter to 00h and its prescaler
// RULE10 - sleep sets timeout_flag_n to 1 and clears powerdown_flag_n to 0
// RULE11 - sleep leaves pin change wake flag unchanged
// RULE12 - after sleep enter low power mode with oscillator halted
// RULE13 - no-operation changes nothing but the program counter
// RULE14 - single-cycle instructions commit their write within one instruction cycle
`ifndef EXEC_DEFS_SVH
`define EXEC_DEFS_SVH
`define OPC_NOP        12'h000
`define OPC_OPTION     12'h002
`define OPC_SLEEP      12'h003
`define OPC_MASK_F     12'hfc0
`define OPC_MASK_WF    12'hfe0
`define OPC_MASK_K     12'hf00
`define OPC_OR_FILE    12'h100
`define OPC_MOVE_FILE  12'h200
`define OPC_STORE      12'h020
`define OPC_LOAD_LIT   12'hc00
`define OPC_RET_LIT    12'h800
`define DEST_BIT       5
`define ADDR_LSB       0
`define ADDR_W         5
`define STATUS_RESET   8'h18
`define STATUS_Z_BIT   2
`define STATUS_PWRDN_BIT 3
`define STATUS_TMOUT_BIT 4
`define OPTION_RESET   8'hff
`define WATCHDOG_CLEAR 8'h00
`define PC_RESET       9'h000
`endif

/* File: pkg/exec_pkg.sv */
package exec_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_FLUSH = 2'b01,
    ST_SLEEP = 2'b10
  } state_type;

  typedef enum logic [2:0] {
    OP_NOP    = 3'b000,
    OP_OR     = 3'b001,
    OP_STORE  = 3'b010,
    OP_MOVE   = 3'b011,
    OP_LIT    = 3'b100,
    OP_OPTION = 3'b101,
    OP_RETLIT = 3'b110,
    OP_SLEEP  = 3'b111
  } op_type;

  typedef struct packed {
    op_type     op;
    logic       dest_file;
    logic [4:0] addr;
    logic [7:0] lit;
  } decoded_type;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [7:0] data;
  } file_wr_type;
endpackage : exec_pkg

/* File: core/file_regs.sv */
`timescale 1ns/1ps
`include "exec_defs.svh"
// small file register memory; read data registered, write forwarded
module file_regs
  import exec_pkg::*;
#(
  parameter int DEPTH = 32
) (
  input  wire logic        i_clk_sys,
  input  wire logic        i_resetn,
  input  wire file_wr_type i_wr,
  input  wire logic [4:0]  i_rd_addr,
  output logic [7:0]       o_rd_data
);
  logic [7:0] mem_r [DEPTH];
  logic [7:0] rd_nxt;

  // forward a same-cycle write so back-to-back ops see fresh data
  always_comb begin
    rd_nxt = mem_r[i_rd_addr];
    if (i_wr.we && i_wr.addr == i_rd_addr) begin
      rd_nxt = i_wr.data;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_wr.we) begin
      mem_r[i_wr.addr] <= i_wr.data;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rd_data <= 8'h00;
    end else begin
      o_rd_data <= rd_nxt;
    end
  end
endmodule : file_regs

/* File: core/accumulator_move_logic_exec.sv */
`timescale 1ns/1ps
`include "exec_defs.svh"
// executes one instruction per i_instr_valid pulse; the file read is
// registered, so an instruction is taken in cycle 0 and committed in cycle 1
module accumulator_move_logic_exec
  import exec_pkg::*;
#(
  parameter int PC_W = 9
) (
  input  wire logic            i_clk_sys,
  input  wire logic            i_resetn,
  input  wire logic            i_instr_valid,
  input  wire logic [11:0]     i_instr,
  input  wire logic [PC_W-1:0] i_stack_top,
  input  wire logic            i_wake,
  input  wire logic            i_pin_change_wake_flag,
  output logic                 o_busy,
  output logic [7:0]           o_accum,
  output logic [7:0]           o_option,
  output logic [7:0]           o_status,
  output logic [PC_W-1:0]      o_pc,
  output logic                 o_discard_fetch,
  output logic [7:0]           o_watchdog_counter,
  output logic [7:0]           o_watchdog_prescaler,
  output logic                 o_osc_run,
  output logic                 o_sleeping,
  output logic                 o_pin_change_wake_flag
);
  decoded_type      dec;
  decoded_type      dec_r;
  decoded_type      dec_nxt;
  logic             exec_r;
  logic             exec_nxt;
  state_type        state_r;
  state_type        state_nxt;
  logic [7:0]       accum_r;
  logic [7:0]       accum_nxt;
  logic [7:0]       option_r;
  logic [7:0]       option_nxt;
  logic [7:0]       status_r;
  logic [7:0]       status_nxt;
  logic [PC_W-1:0]  pc_r;
  logic [PC_W-1:0]  pc_nxt;
  logic             discard_r;
  logic             discard_nxt;
  logic [7:0]       dog_r;
  logic [7:0]       dog_nxt;
  logic [7:0]       pre_r;
  logic [7:0]       pre_nxt;
  logic [7:0]       file_rd;
  logic [7:0]       result;
  file_wr_type      wr;

  // decode the incoming word; unknown codes act as no-operation
  always_comb begin
    dec.op        = OP_NOP;
    dec.dest_file = i_instr[`DEST_BIT];
    dec.addr      = i_instr[`ADDR_LSB +: `ADDR_W];
    dec.lit       = i_instr[7:0];
    if (i_instr == `OPC_OPTION) begin
      dec.op = OP_OPTION;
    end else if (i_instr == `OPC_SLEEP) begin
      dec.op = OP_SLEEP;
    end else if ((i_instr & `OPC_MASK_F) == `OPC_OR_FILE) begin
      dec.op = OP_OR;
    end else if ((i_instr & `OPC_MASK_F) == `OPC_MOVE_FILE) begin
      dec.op = OP_MOVE;
    end else if ((i_instr & `OPC_MASK_WF) == `OPC_STORE) begin
      dec.op = OP_STORE;
    end else if ((i_instr & `OPC_MASK_K) == `OPC_LOAD_LIT) begin
      dec.op = OP_LIT;
    end else if ((i_instr & `OPC_MASK_K) == `OPC_RET_LIT) begin
      dec.op = OP_RETLIT;
    end
  end

  // capture stage: accepted only while running and not flushing
  always_comb begin
    exec_nxt = 1'b0;
    dec_nxt  = dec_r;
    if (state_r == ST_RUN && !exec_r && i_instr_valid) begin
      exec_nxt = 1'b1;
      dec_nxt  = dec;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      exec_r <= 1'b0;
      dec_r  <= '0;
    end else begin
      exec_r <= exec_nxt;
      dec_r  <= dec_nxt;
    end
  end

  file_regs #(
    .DEPTH (32)
  ) u_file_regs (
    .i_clk_sys (i_clk_sys),
    .i_resetn  (i_resetn),
    .i_wr      (wr),
    .i_rd_addr (dec.addr),
    .o_rd_data (file_rd)
  );

  // datapath result for file-sourced ops
  always_comb begin
    result = file_rd;
    if (dec_r.op == OP_OR) begin
      result = accum_r | file_rd; // RULE1
    end
  end

  // file write port, committed in the execute cycle
  always_comb begin
    wr.we   = 1'b0;
    wr.addr = dec_r.addr;
    wr.data = result;
    if (exec_r) begin
      if ((dec_r.op == OP_OR || dec_r.op == OP_MOVE) && dec_r.dest_file) begin
        wr.we = 1'b1; // RULE1 RULE3 RULE14
      end else if (dec_r.op == OP_STORE) begin
        wr.we   = 1'b1; // RULE2
        wr.data = accum_r;
      end
    end
  end

  // architectural state: accumulator, option, status, pc, watchdog
  always_comb begin
    state_nxt   = state_r;
    accum_nxt   = accum_r;
    option_nxt  = option_r;
    status_nxt  = status_r;
    pc_nxt      = pc_r;
    discard_nxt = 1'b0;
    dog_nxt     = dog_r;
    pre_nxt     = pre_r;
    // free-running watchdog count; frozen while the oscillator is stopped
    if (state_r != ST_SLEEP) begin
      pre_nxt = pre_r + 8'h01;
      if (pre_r == 8'hff) begin
        dog_nxt = dog_r + 8'h01;
      end
    end
    case (state_r)
      ST_RUN: begin
        if (exec_r) begin
          pc_nxt = pc_r + PC_W'(1); // RULE13
          case (dec_r.op)
            OP_OR, OP_MOVE: begin
              if (!dec_r.dest_file) begin
                accum_nxt = result; // RULE1 RULE3
              end
              status_nxt[`STATUS_Z_BIT] = (result == 8'h00); // RULE1 RULE3
            end
            OP_LIT: begin
              accum_nxt = dec_r.lit; // RULE4
            end
            OP_OPTION: begin
              option_nxt = accum_r; // RULE5
            end
            OP_RETLIT: begin
              accum_nxt   = dec_r.lit; // RULE6
              pc_nxt      = i_stack_top; // RULE7
              discard_nxt = 1'b1; // RULE8
              state_nxt   = ST_FLUSH; // RULE8
            end
            OP_SLEEP: begin
              dog_nxt                       = `WATCHDOG_CLEAR; // RULE9
              pre_nxt                       = 8'h00; // RULE9
              status_nxt[`STATUS_TMOUT_BIT] = 1'b1; // RULE10
              status_nxt[`STATUS_PWRDN_BIT] = 1'b0; // RULE10
              state_nxt                  = ST_SLEEP; // RULE12
            end
            default: begin
            end
          endcase
        end
      end
      ST_FLUSH: begin
        // second cycle swallows the already fetched word
        discard_nxt = 1'b1; // RULE8
        state_nxt   = ST_RUN;
      end
      ST_SLEEP: begin
        // oscillator stopped: only a wake event restarts the core
        if (i_wake) begin
          state_nxt = ST_RUN; // RULE12
        end
      end
      default: begin
        state_nxt = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r   <= ST_RUN;
      accum_r   <= 8'h00;
      option_r  <= `OPTION_RESET;
      status_r  <= `STATUS_RESET;
      pc_r      <= `PC_RESET;
      discard_r <= 1'b0;
      dog_r     <= `WATCHDOG_CLEAR;
      pre_r     <= 8'h00;
    end else begin
      state_r   <= state_nxt;
      accum_r   <= accum_nxt;
      option_r  <= option_nxt;
      status_r  <= status_nxt;
      pc_r      <= pc_nxt;
      discard_r <= discard_nxt;
      dog_r     <= dog_nxt;
      pre_r     <= pre_nxt;
    end
  end

  // outputs; the wake flag is owned elsewhere and passed through untouched
  assign o_busy                 = exec_r || state_r != ST_RUN;
  assign o_accum                = accum_r;
  assign o_option               = option_r;
  assign o_status               = status_r;
  assign o_pc                   = pc_r;
  assign o_discard_fetch        = discard_r;
  assign o_watchdog_counter     = dog_r;
  assign o_watchdog_prescaler   = pre_r;
  assign o_sleeping             = state_r == ST_SLEEP;
  assign o_osc_run              = state_r != ST_SLEEP; // RULE12
  assign o_pin_change_wake_flag = i_pin_change_wake_flag; // RULE11
endmodule : accumulator_move_logic_exec

/* File: sim/exec_chk.sv */
`timescale 1ns/1ps
// port-level watcher for the execute block
module exec_chk #(
  parameter int PC_W = 9
) (
  input wire logic            i_clk_sys,
  input wire logic            i_resetn,
  input wire logic            i_instr_valid,
  input wire logic [11:0]     i_instr,
  input wire logic [PC_W-1:0] i_stack_top,
  input wire logic            i_pin_change_wake_flag,
  input wire logic            o_busy,
  input wire logic [7:0]      o_accum,
  input wire logic [7:0]      o_status,
  input wire logic [PC_W-1:0] o_pc,
  input wire logic            o_discard_fetch,
  input wire logic [7:0]      o_watchdog_counter,
  input wire logic [7:0]      o_watchdog_prescaler,
  input wire logic            o_osc_run,
  input wire logic            o_sleeping,
  input wire logic            o_pin_change_wake_flag
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // a word is taken only when the block is idle
  logic tk;
  assign tk = i_instr_valid && !o_busy;
  property p_lit; tk && i_instr[11:8] == 4'hc |=> ##1 o_accum == $past(i_instr[7:0], 2);
  endproperty
  a_lit: assert property (p_lit) else $error("literal load wrong");
  property p_store; tk && i_instr[11:5] == 7'h01 |=> ##1 o_status == $past(o_status, 2);
  endproperty
  a_store: assert property (p_store) else $error("store touched flags");
  property p_ret_pc; tk && i_instr[11:8] == 4'h8 |=> ##1 o_pc == $past(i_stack_top); endproperty
  a_ret_pc: assert property (p_ret_pc) else $error("return pc wrong");
  property p_ret_disc; tk && i_instr[11:8] == 4'h8 |=> ##1 o_discard_fetch [*2]; endproperty
  a_ret_disc: assert property (p_ret_disc) else $error("no discard");
  property p_dog_clr; tk && i_instr == 12'h003 |=>
    ##1 {o_watchdog_counter, o_watchdog_prescaler} == 16'h0000; endproperty
  a_dog_clr: assert property (p_dog_clr) else $error("watchdog not cleared");
  property p_flags; tk && i_instr == 12'h003 |=> ##1 o_status[4:3] == 2'b10; endproperty
  a_flags: assert property (p_flags) else $error("sleep flags wrong");
  property p_wake; o_pin_change_wake_flag == i_pin_change_wake_flag; endproperty
  a_wake: assert property (p_wake) else $error("wake flag altered");
  property p_osc; tk && i_instr == 12'h003 |=> ##1 !o_osc_run && o_sleeping; endproperty
  a_osc: assert property (p_osc) else $error("oscillator not halted");
  // no-operation leaves accumulator and flags alone, pc steps by one
  property p_nop; tk && i_instr == 12'h000 |=> ##1
    o_accum == $past(o_accum, 2) && o_status == $past(o_status, 2) &&
    o_pc == $past(o_pc, 2) + PC_W'(1); endproperty
  a_nop: assert property (p_nop) else $error("nop changed state");
endmodule : exec_chk

bind accumulator_move_logic_exec exec_chk #(.PC_W(PC_W)) chk_i (.i_clk_sys, .i_resetn,
  .i_instr_valid, .i_instr, .i_stack_top, .i_pin_change_wake_flag, .o_busy, .o_accum,
  .o_status, .o_pc, .o_discard_fetch, .o_watchdog_counter, .o_watchdog_prescaler, .o_osc_run,
  .o_sleeping, .o_pin_change_wake_flag);

/* File: sim/prog_mem.sv */
`timescale 1ns/1ps
// program memory side: offers one word, holds it until taken
module prog_mem (
  input  wire logic  i_clk_sys,
  input  wire logic  i_busy,
  output logic       o_valid,
  output logic [11:0] o_instr
);
  initial begin
    o_valid = 1'b0;
    o_instr = 12'h5a5;
  end
  // released lines get the inverse so no stale word looks valid
  task automatic issue(input logic [11:0] w);
    @(negedge i_clk_sys);
    o_valid = 1'b1;
    o_instr = w;
    while (i_busy) @(negedge i_clk_sys);
    @(negedge i_clk_sys);
    o_valid = 1'b0;
    o_instr = ~w;
  endtask : issue
endmodule : prog_mem

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  logic        i_clk_sys = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_wake = 1'b0;
  logic        i_pin_change_wake_flag = 1'b0;
  logic [8:0]  i_stack_top = 9'h000;
  logic [11:0] i_instr;
  logic        i_instr_valid, o_busy, o_discard_fetch, o_osc_run, o_sleeping;
  logic        o_pin_change_wake_flag;
  logic [7:0]  o_accum, o_option, o_status, o_watchdog_counter, o_watchdog_prescaler, e_acc, e_st;
  logic [7:0]  e_opt, fr [32];
  logic [8:0]  o_pc, e_pc;
  logic [31:0] seed = 32'h7f34, x;
  int          n_mismatch = 0, checked = 0, cyc = 0;
  logic [11:0] corner [14] = '{12'hc00, 12'h03f, 12'h21f, 12'h23f, 12'hcff, 12'h13f, 12'h11f,
                               12'h002, 12'h8ff, 12'h800, 12'h003, 12'h003, 12'h000, 12'h0a5};
  logic [11:0] base [8] = '{12'h100, 12'h200, 12'h020, 12'hc00,
                            12'h002, 12'h800, 12'h003, 12'h000};
  logic [11:0] mask [8] = '{12'h03f, 12'h03f, 12'h01f, 12'h0ff,
                            12'h000, 12'h0ff, 12'h000, 12'h000};

  accumulator_move_logic_exec #(.PC_W(9)) DUT (.i_clk_sys, .i_resetn, .i_instr_valid, .i_instr,
    .i_stack_top, .i_wake, .i_pin_change_wake_flag, .o_busy, .o_accum, .o_option, .o_status,
    .o_pc, .o_discard_fetch, .o_watchdog_counter, .o_watchdog_prescaler, .o_osc_run, .o_sleeping,
    .o_pin_change_wake_flag);
  prog_mem mem (.i_clk_sys, .i_busy(o_busy), .o_valid(i_instr_valid), .o_instr(i_instr));

  initial forever #2.5 i_clk_sys = ~i_clk_sys;

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // expected state after one word; unknown codes fall through as nop
  function automatic void predict(input logic [11:0] w);
    logic [7:0] r;
    r = (w[11:8] == 4'h1) ? (fr[w[4:0]] | e_acc) : fr[w[4:0]];
    e_pc = e_pc + 9'h001;
    if (w[11:6] == 6'h04 || w[11:6] == 6'h08) begin
      e_st[2] = (r == 8'h00);
      if (w[5]) fr[w[4:0]] = r;
      else e_acc = r;
    end
    if (w[11:5] == 7'h01) fr[w[4:0]] = e_acc;
    if (w[11:8] == 4'hc || w[11:8] == 4'h8) e_acc = w[7:0];
    if (w[11:8] == 4'h8) e_pc = i_stack_top;
    if (w == 12'h002) e_opt = e_acc;
    if (w == 12'h003) e_st[4:3] = 2'b10;
  endfunction : predict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // one word end to end; wake is raised only once the sleep state is checked
  task automatic run(input logic [11:0] w);
    x = rnd();
    i_stack_top = x[8:0];
    i_pin_change_wake_flag = x[9];
    mem.issue(w);
    chk(o_busy, 16'h0001);
    predict(w);
    @(negedge i_clk_sys);
    if (w[11:8] == 4'h8) begin
      chk(o_discard_fetch, 16'h0001);
      @(negedge i_clk_sys);
      chk(o_discard_fetch, 16'h0001);
    end
    if (w == 12'h003) begin
      chk({o_watchdog_counter, o_watchdog_prescaler}, 16'h0000);
      chk(o_status, e_st);
      chk(o_pin_change_wake_flag, i_pin_change_wake_flag);
      chk({o_osc_run, o_sleeping}, 16'h0001);
      i_wake = 1'b1;
    end
    for (int k = 0; k < 8 && o_busy !== 1'b0; k++) @(negedge i_clk_sys);
    i_wake = 1'b0;
    chk(o_busy, 16'h0000);
    chk(o_accum, e_acc);
    chk(o_status, e_st);
    chk(o_option, e_opt);
    chk(o_pc, e_pc);
  endtask : run

  task automatic close_out();
    if (n_mismatch == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  // hang guard, well above the roughly 1200 cycles the run needs
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  initial begin
    {e_acc, e_opt, e_st, e_pc} = {8'h00, 8'hff, 8'h18, 9'h000};
    repeat (3) @(posedge i_clk_sys);
    @(negedge i_clk_sys);
    i_resetn = 1'b1;
    // file registers power up unknown, so seed them all first
    for (int i = 0; i < 32; i++) begin
      run({4'hc, 8'(i * 37)});
      run({7'h01, 5'(i)});
    end
    foreach (corner[j]) run(corner[j]);
    repeat (300) begin
      x = rnd();
      run(base[x[14:12]] | (x[11:0] & mask[x[14:12]]));
    end
    close_out();
  end
endmodule : tb
